// >>> core/stream_receiver_pkg.sv
// Register map, field positions, reset values and types of the stream receiver.
// Assumes one system clock; the core synchronises all stream pins itself.
package stream_receiver_pkg;
  // Overview of operation
  // - Slave receiver, packets stored in 188-byte units
  // - One data line serial, eight lines parallel
  // - Data and qualifiers sampled on stream clock
  // - Input buffer 256 bytes: 32 entries, 64 bits
  // - Bytes packed into 32-bit words, big endian unless bit 13 set
  // - Control bit 0 enables receiver, off after reset
  // - Control bit 1: serial 0, parallel 1
  // - Control bit 4: serial MSB or LSB first
  // - Control bit 5: source edge, sample other
  // - Control bit 6: sync lasts byte or bit
  // - Control bit 7: sync input polarity
  // - Control bit 8: valid input polarity
  // - Control bit 9: error input polarity
  // - Control bit 10: accept or discard error packets
  // - Status bit 2 pending, write-one clear, bit 11 gates
  // - Control bit 13: big or little endian storage
  // - Status bit 1 overflow, sticky, write-one clear
  // - Status bit 0 packet error, sticky, write-one clear
  // - Data register read pops 64-deep word queue

  localparam logic [7:0]  OFS_CONTROL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS       = 8'h04;
  localparam logic [7:0]  OFS_RXWORD       = 8'h08;

  localparam int          CTL_ENABLE       = 0;
  localparam int          CTL_MODE         = 1;
  localparam int          CTL_BIT_ORDER    = 4;
  localparam int          CTL_EDGE         = 5;
  localparam int          CTL_SYNC_LEN     = 6;
  localparam int          CTL_SYNC_POL     = 7;
  localparam int          CTL_VALID_POL    = 8;
  localparam int          CTL_ERR_POL      = 9;
  localparam int          CTL_ERR_POLICY   = 10;
  localparam int          CTL_IRQ_EN       = 11;
  localparam int          CTL_DRQ_EN       = 12;
  localparam int          CTL_BYTE_ORDER   = 13;

  localparam int          STS_PKT_ERR      = 0;
  localparam int          STS_OVERFLOW     = 1;
  localparam int          STS_PENDING      = 2;

  localparam logic [31:0] CONTROL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CONTROL_MASK     = 32'h0000_3ff3;

  localparam int          PACKET_BYTES     = 188;
  localparam int          IBUF_ENTRIES_DEF = 32;
  localparam int          IBUF_WIDTH       = 64;
  localparam int          QUEUE_DEPTH_DEF  = 64;

  typedef struct packed {
    logic [7:0] data;
    logic       error;
    logic       valid;
    logic       sync;
    logic       clock;
  } stream_pins_t;

  typedef enum logic [1:0] {
    HUNT      = 2'b01,
    IN_PACKET = 2'b10
  } rx_state_t;
endpackage

// >>> core/stream_receiver.sv
// Transport stream receiver core: pin sampling, packet framing, buffers, registers.
// Assumes pins come from the source's clock domain and a register master on clk.
`timescale 1ns/100ps
module stream_receiver
  import stream_receiver_pkg::*;
#(
  parameter int IBUF_ENTRIES = IBUF_ENTRIES_DEF,
  parameter int QUEUE_DEPTH  = QUEUE_DEPTH_DEF
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire stream_pins_t stream_in,
  output logic              irq,
  output logic              dma_request
);
  localparam int             IBW       = $clog2(IBUF_ENTRIES * 2) + 1;
  localparam int             QW        = $clog2(QUEUE_DEPTH) + 1;
  localparam logic [IBW-1:0] IB_WORDS  = IBW'(IBUF_ENTRIES * 2);
  localparam logic [QW-1:0]  Q_WORDS   = QW'(QUEUE_DEPTH);
  localparam logic [7:0]     LAST_BYTE = 8'(PACKET_BYTES - 1);

  // Pin synchronisers
  stream_pins_t pins_s1_r;
  stream_pins_t pins_s2_r;
  logic         sclk_prev_r;

  // Control and status
  logic [31:0]  ctrl_r;
  logic [31:0]  ctrl_nxt;
  logic         pend_r;
  logic         pend_nxt;
  logic         ovf_r;
  logic         ovf_nxt;
  logic         perr_r;
  logic         perr_nxt;
  logic [31:0]  rdata_nxt;
  logic         irq_nxt;
  logic         drq_nxt;
  logic         q_pop;
  logic         sts_wr;

  // Receiver
  rx_state_t    st_r;
  rx_state_t    st_nxt;
  logic [2:0]   bitcnt_r;
  logic [2:0]   bitcnt_nxt;
  logic [7:0]   shift_r;
  logic [7:0]   shift_nxt;
  logic         sync_prev_r;
  logic         sync_prev_nxt;
  logic [7:0]   bidx_r;
  logic [7:0]   bidx_nxt;
  logic [31:0]  word_r;
  logic [31:0]  word_nxt;
  logic         bad_r;
  logic         bad_nxt;
  logic         drop_r;
  logic         drop_nxt;
  logic         ev_commit;
  logic         ev_ovf;
  logic         ev_perr;

  // Input buffer and receive queue
  logic [IBUF_WIDTH-1:0] ibuf_r [IBUF_ENTRIES];
  logic [31:0]           q_r [QUEUE_DEPTH];
  logic [IBW-1:0]        wp_r;
  logic [IBW-1:0]        wp_nxt;
  logic [IBW-1:0]        sp_r;
  logic [IBW-1:0]        sp_nxt;
  logic [IBW-1:0]        cp_r;
  logic [IBW-1:0]        cp_nxt;
  logic [IBW-1:0]        rp_r;
  logic [IBW-1:0]        rp_nxt;
  logic [QW-1:0]         qw_r;
  logic [QW-1:0]         qw_nxt;
  logic [QW-1:0]         qr_r;
  logic [QW-1:0]         qr_nxt;
  logic                  ib_we;
  logic [31:0]           ib_wdata;
  logic                  q_we;
  logic [31:0]           ib_rword;
  logic                  q_empty;

  // Both stages always run so the link clock is seen even while disabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_s1_r   <= '0;
      pins_s2_r   <= '0;
      sclk_prev_r <= 1'b0;
    end else begin
      pins_s1_r   <= stream_in;
      pins_s2_r   <= pins_s1_r;
      sclk_prev_r <= pins_s2_r.clock;
    end
  end

  // Receiver, framing and buffer pointers
  always_comb begin
    logic       take;
    logic       sync_a;
    logic       valid_a;
    logic       err_a;
    logic       start;
    logic       got;
    logic       inpkt;
    logic       bad;
    logic       drop;
    logic [7:0] byte_v;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic [1:0] lane;
    logic [7:0] idx;
    logic [IBW-1:0] wp;
    take    = 1'b0;
    sync_a  = 1'b0;
    valid_a = 1'b0;
    err_a   = 1'b0;
    start   = 1'b0;
    got     = 1'b0;
    byte_v  = 8'h00;
    sh      = 8'h00;
    cnt     = 3'h0;
    lane    = 2'h0;
    inpkt   = 1'b0;
    bad     = 1'b0;
    drop    = 1'b0;
    idx     = 8'h00;
    wp      = '0;
    st_nxt        = st_r;
    bitcnt_nxt    = bitcnt_r;
    shift_nxt     = shift_r;
    sync_prev_nxt = sync_prev_r;
    word_nxt      = word_r;
    cp_nxt        = cp_r;
    sp_nxt        = sp_r;
    ib_we         = 1'b0;
    ib_wdata      = 32'h0000_0000;
    ev_commit     = 1'b0;
    ev_ovf        = 1'b0;
    ev_perr       = 1'b0;
    // Data moves on one edge, so sample on the opposite one
    if (ctrl_r[CTL_EDGE]) begin
      take = pins_s2_r.clock & ~sclk_prev_r;
    end else begin
      take = ~pins_s2_r.clock & sclk_prev_r;
    end
    take    = take & ctrl_r[CTL_ENABLE];
    sync_a  = pins_s2_r.sync ^ ctrl_r[CTL_SYNC_POL];
    valid_a = pins_s2_r.valid ^ ctrl_r[CTL_VALID_POL];
    err_a   = pins_s2_r.error ^ ctrl_r[CTL_ERR_POL];
    if (take && valid_a) begin
      sync_prev_nxt = sync_a;
      if (ctrl_r[CTL_MODE]) begin
        start  = sync_a;
        got    = 1'b1;
        byte_v = pins_s2_r.data;
      end else begin
        // Byte-long sync would restart every bit, so only its onset counts
        start = sync_a & (ctrl_r[CTL_SYNC_LEN] | ~sync_prev_r);
        if (ctrl_r[CTL_BIT_ORDER]) begin
          sh = {pins_s2_r.data[0], shift_r[7:1]};
        end else begin
          sh = {shift_r[6:0], pins_s2_r.data[0]};
        end
        shift_nxt  = sh;
        cnt        = start ? 3'h0 : bitcnt_r;
        bitcnt_nxt = cnt + 3'h1;
        got        = (cnt == 3'h7);
        byte_v     = sh;
      end
    end
    // A new sync abandons any partial packet
    inpkt = start | (st_r == IN_PACKET);
    idx   = start ? 8'h00 : bidx_r;
    bad   = start ? 1'b0 : bad_r;
    drop  = start ? 1'b0 : drop_r;
    wp    = start ? sp_r : wp_r;
    if (start) begin
      st_nxt = IN_PACKET;
    end
    if (take && valid_a && inpkt) begin
      bad = bad | err_a;
    end
    if (got && inpkt) begin
      lane = ctrl_r[CTL_BYTE_ORDER] ? idx[1:0] : 2'h3 - idx[1:0];
      word_nxt[{lane, 3'b000} +: 8] = byte_v;
      if (idx[1:0] == 2'h3) begin
        if (IBW'(wp - rp_r) == IB_WORDS) begin
          drop   = 1'b1;
          ev_ovf = 1'b1;
        end else if (!drop) begin
          ib_we    = 1'b1;
          ib_wdata = word_nxt;
          wp       = wp + 1'b1;
        end
      end
      if (idx == LAST_BYTE) begin
        st_nxt  = HUNT;
        ev_perr = bad;
        if (drop || (bad && ctrl_r[CTL_ERR_POLICY])) begin
          wp = sp_r;
        end else begin
          cp_nxt    = wp;
          sp_nxt    = wp;
          ev_commit = 1'b1;
        end
      end
      idx = idx + 8'h01;
    end
    wp_nxt   = wp;
    bidx_nxt = idx;
    bad_nxt  = bad;
    drop_nxt = drop;
    // Disabling drops only the packet in flight; committed data stays
    if (!ctrl_r[CTL_ENABLE]) begin
      st_nxt     = HUNT;
      wp_nxt     = sp_r;
      bitcnt_nxt = 3'h0;
    end
  end

  // Mover from input buffer into the receive queue
  always_comb begin
    if (rp_r[0]) begin
      ib_rword = ibuf_r[rp_r[IBW-2:1]][63:32];
    end else begin
      ib_rword = ibuf_r[rp_r[IBW-2:1]][31:0];
    end
    q_empty = (qw_r == qr_r);
    q_we    = (rp_r != cp_r) && (QW'(qw_r - qr_r) != Q_WORDS);
    rp_nxt  = rp_r + IBW'(q_we);
    qw_nxt  = qw_r + QW'(q_we);
    qr_nxt  = qr_r + QW'(q_pop);
  end

  // Register slave; status set wins over a same-cycle clear
  always_comb begin
    q_pop     = 1'b0;
    rdata_nxt = 32'h0000_0000;
    sts_wr    = reg_wr && (reg_addr == OFS_STATUS);
    ctrl_nxt  = ctrl_r;
    if (reg_wr && (reg_addr == OFS_CONTROL)) begin
      ctrl_nxt = reg_wdata & CONTROL_MASK;
    end
    pend_nxt = ev_commit | (pend_r & ~(sts_wr & reg_wdata[STS_PENDING]));
    ovf_nxt  = ev_ovf | (ovf_r & ~(sts_wr & reg_wdata[STS_OVERFLOW]));
    perr_nxt = ev_perr | (perr_r & ~(sts_wr & reg_wdata[STS_PKT_ERR]));
    if (reg_rd) begin
      if (reg_addr == OFS_CONTROL) begin
        rdata_nxt = ctrl_r;
      end else if (reg_addr == OFS_STATUS) begin
        rdata_nxt = {29'h0, pend_r, ovf_r, perr_r};
      end else if (reg_addr == OFS_RXWORD && !q_empty) begin
        rdata_nxt = q_r[qr_r[QW-2:0]];
        q_pop     = 1'b1;
      end
    end
    irq_nxt = pend_r & ctrl_r[CTL_IRQ_EN];
    drq_nxt = ctrl_r[CTL_DRQ_EN] & ~q_empty;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r      <= CONTROL_RESET;
      pend_r      <= 1'b0;
      ovf_r       <= 1'b0;
      perr_r      <= 1'b0;
      reg_rdata   <= 32'h0000_0000;
      irq         <= 1'b0;
      dma_request <= 1'b0;
      st_r        <= HUNT;
      bitcnt_r    <= 3'h0;
      shift_r     <= 8'h00;
      sync_prev_r <= 1'b0;
      bidx_r      <= 8'h00;
      word_r      <= 32'h0000_0000;
      bad_r       <= 1'b0;
      drop_r      <= 1'b0;
      wp_r        <= '0;
      sp_r        <= '0;
      cp_r        <= '0;
      rp_r        <= '0;
      qw_r        <= '0;
      qr_r        <= '0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      pend_r      <= pend_nxt;
      ovf_r       <= ovf_nxt;
      perr_r      <= perr_nxt;
      reg_rdata   <= rdata_nxt;
      irq         <= irq_nxt;
      dma_request <= drq_nxt;
      st_r        <= st_nxt;
      bitcnt_r    <= bitcnt_nxt;
      shift_r     <= shift_nxt;
      sync_prev_r <= sync_prev_nxt;
      bidx_r      <= bidx_nxt;
      word_r      <= word_nxt;
      bad_r       <= bad_nxt;
      drop_r      <= drop_nxt;
      wp_r        <= wp_nxt;
      sp_r        <= sp_nxt;
      cp_r        <= cp_nxt;
      rp_r        <= rp_nxt;
      qw_r        <= qw_nxt;
      qr_r        <= qr_nxt;
    end
  end

  // Storage needs no reset; pointers guard every read
  always_ff @(posedge clk) begin
    if (ib_we) begin
      if (wp_r[0]) begin
        ibuf_r[wp_r[IBW-2:1]][63:32] <= ib_wdata;
      end else begin
        ibuf_r[wp_r[IBW-2:1]][31:0] <= ib_wdata;
      end
    end
    if (q_we) begin
      q_r[qw_r[QW-2:0]] <= ib_rword;
    end
  end
endmodule

// >>> verif/stream_receiver_monitor.sv
// Checker for the stream receiver: register reads and event outputs.
// Bound to the core top module; sees its ports only.
`timescale 1ns/100ps
module stream_receiver_monitor
  import stream_receiver_pkg::*;
(
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic [7:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata,
  input wire stream_pins_t stream_in,
  input wire logic         irq,
  input wire logic         dma_request
);
  logic [31:0] ctl_r;
  logic [31:0] ctl_nxt;
  // Shadow copy, so no probe into the core
  always_comb begin
    ctl_nxt = ctl_r;
    if (reg_wr && reg_addr == OFS_CONTROL) begin
      ctl_nxt = reg_wdata & 32'h0000_3ff3;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_r <= 32'h0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence clear_all;
    reg_wr && reg_addr == OFS_STATUS && reg_wdata[2:0] == 3'h7;
  endsequence
  sequence read_status;
    reg_rd && reg_addr == OFS_STATUS;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_ctl_read: assert property (reg_rd && reg_addr == OFS_CONTROL |=> reg_rdata == ctl_r)
    else $error("control readback wrong");
  a_irq_gate: assert property (irq |-> $past(ctl_r[CTL_IRQ_EN]))
    else $error("irq while disabled");
  a_dma_gate: assert property (dma_request |-> $past(ctl_r[CTL_DRQ_EN]))
    else $error("dma request while disabled");
  a_dma_off: assert property ($fell(ctl_r[CTL_DRQ_EN]) |=> !dma_request)
    else $error("dma request stays after disable");
  a_irq_off: assert property ($fell(ctl_r[CTL_IRQ_EN]) |=> !irq)
    else $error("irq stays after disable");
  a_clear_read: assert property (clear_all ##2 read_status |=> reg_rdata[2:0] == 3'h0)
    else $error("status not cleared");
  a_irq_clear: assert property (clear_all |-> ##2 !irq)
    else $error("irq stays after clear");
endmodule

// >>> verif/stream_source.sv
// Transport stream source model driving the receiver's stream pins.
// Assumes the bench calls send after programming the control word.
`timescale 1ns/100ps
module stream_source
  import stream_receiver_pkg::*;
(
  output stream_pins_t pins
);
  initial begin
    pins = '0;
  end
  // Clock runs only within a packet
  task automatic send(input logic [31:0] c, input logic [7:0] seed, input bit err);
    logic [7:0] b;
    for (int i = 0; i < PACKET_BYTES; i++) begin
      b = seed + 8'(i);
      for (int j = 0; j < (c[1] ? 1 : 8); j++) begin
        pins.clock <= ~c[5];
        pins.data  <= c[1] ? b : {8{c[4] ? b[j] : b[7-j]}};
        pins.sync  <= ((i == 0) && (j == 0 || !c[6])) ^ c[7];
        pins.valid <= ~c[8];
        pins.error <= (err && i == 5) ^ c[9];
        #200;
        pins.clock <= c[5];
        #200;
      end
    end
    // Released data lines flip, never hold stale data; qualifiers go inactive
    pins.data  <= ~pins.data;
    pins.valid <= c[8];
    pins.sync  <= c[7];
    pins.error <= c[9];
  endtask
endmodule

// >>> verif/stream_receiver_tb.sv
// Self-checking bench for the stream receiver: register tasks, packet tests.
// Assumes the source model and the bound checker.
`timescale 1ns/100ps
`define CHK(n, g, x) check(n, 32'(g), 32'(x))
module stream_receiver_tb
  import stream_receiver_pkg::*;
  ;
  logic         clk = 1'b0;
  logic         sys_rst;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_rdata;
  logic         irq;
  logic         dma_request;
  stream_pins_t pins;
  int           err_count = 0;
  int           samples_checked = 0;
  logic [31:0]  d;

  always #25 clk = ~clk;

  stream_source u_stream_source (.pins(pins));
  stream_receiver u_stream_receiver (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stream_in(pins), .irq(irq), .dma_request(dma_request));

  task automatic check(input string n, input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  function automatic logic [31:0] word_of(input logic [7:0] s, input int k, input logic le);
    logic [7:0] b0;
    b0 = s + 8'(4 * k);
    return le ? {b0 + 8'h3, b0 + 8'h2, b0 + 8'h1, b0} : {b0, b0 + 8'h1, b0 + 8'h2, b0 + 8'h3};
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Fixed wait: 47 words at one per clock after commit
  task automatic run_pkt(input logic [31:0] c, input logic [7:0] s, input bit e);
    logic [31:0] v;
    logic        drop;
    drop = e & c[10];
    wr(OFS_CONTROL, c);
    u_stream_source.send(c, s, e);
    repeat (80) @(posedge clk);
    // Off the edge, so outputs are settled when looked at
    #1;
    `CHK("irq", irq, c[11] & ~drop);
    `CHK("drq", dma_request, c[12] & ~drop);
    rd(OFS_STATUS, v);
    `CHK("status", v, {~drop, 1'b0, e});
    for (int k = 0; k < 47 && !drop; k++) begin
      rd(OFS_RXWORD, v);
      `CHK("word", v, word_of(s, k, c[13]));
    end
    rd(OFS_RXWORD, v);
    `CHK("empty", v, 32'h0);
    `CHK("drq_empty", dma_request, 1'b0);
    wr(OFS_STATUS, 32'h7);
    rd(OFS_STATUS, v);
    `CHK("cleared", v, 32'h0);
  endtask

  initial begin
    #3_000_000;
    err_count++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_CONTROL, d);
    `CHK("ctl_reset", d, 32'h0);
    wr(OFS_CONTROL, 32'hffff_ffff);
    rd(OFS_CONTROL, d);
    `CHK("ctl_mask", d, 32'h0000_3ff3);
    rd(8'h0c, d);
    `CHK("unmapped", d, 32'h0);
    wr(OFS_CONTROL, 32'h1800);
    u_stream_source.send(32'h1800, 8'h10, 1'b0);
    repeat (80) @(posedge clk);
    rd(OFS_STATUS, d);
    `CHK("off_status", d, 32'h0);
    `CHK("off_drq", dma_request, 1'b0);
    run_pkt(32'h1803, 8'h00, 1'b0);
    run_pkt(32'h2ba3, 8'h40, 1'b1);
    run_pkt(32'h1801, 8'h80, 1'b0);
    run_pkt(32'h0851, 8'hc0, 1'b0);
    run_pkt(32'h1403, 8'h20, 1'b1);
    wr(OFS_CONTROL, 32'h3);
    // Gap keeps line release and next packet in separate steps
    repeat (4) begin
      u_stream_source.send(32'h3, 8'h55, 1'b0);
      #400;
    end
    repeat (80) @(posedge clk);
    rd(OFS_STATUS, d);
    `CHK("overflow", d, 32'h6);
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, d);
    `CHK("ovf_clear", d, 32'h4);
    conclude();
  end
endmodule

bind stream_receiver stream_receiver_monitor u_stream_receiver_monitor (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .stream_in(stream_in), .irq(irq), .dma_request(dma_request));
